// ### hdl/t8coc_regs.vh
// register map, field positions and constants of the 8-bit timer
`ifndef T8COC_REGS_VH
`define T8COC_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define T8COC_OFS_CTL_A    8'h30
`define T8COC_OFS_COUNT    8'h32
`define T8COC_OFS_CTL_B    8'h33
`define T8COC_OFS_CMP_A    8'h36
`define T8COC_OFS_CMP_B    8'h37
`define T8COC_OFS_STATUS   8'h38
`define T8COC_OFS_MASK     8'h39
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define T8COC_CTLA_MODE_A  7:6
`define T8COC_CTLA_MODE_B  5:4
`define T8COC_CTLA_WAVE    1:0
`define T8COC_CTLB_UPPER   3
`define T8COC_CTLB_SRC     2:0
`define T8COC_ST_OVF       0
`define T8COC_ST_MATCH_A   1
`define T8COC_ST_MATCH_B   2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define T8COC_RST_BYTE     8'h00
`define T8COC_RST_SRC      3'h0
`define T8COC_RST_FLAGS    3'h0
// ----------------------------------------------------------------
// counter limits
// ----------------------------------------------------------------
`define T8COC_MAX          8'hFF
`define T8COC_BOTTOM       8'h00
// ----------------------------------------------------------------
// prescaler taps: low bits all ones gives divide by 8/64/256/1024
// ----------------------------------------------------------------
`define T8COC_DIV8_MASK    10'h007
`define T8COC_DIV64_MASK   10'h03F
`define T8COC_DIV256_MASK  10'h0FF
`define T8COC_DIV1024_MASK 10'h3FF
// ----------------------------------------------------------------
// tick source codes
// ----------------------------------------------------------------
`define T8COC_SRC_STOP     3'h0
`define T8COC_SRC_CLK      3'h1
`define T8COC_SRC_DIV8     3'h2
`define T8COC_SRC_DIV64    3'h3
`define T8COC_SRC_DIV256   3'h4
`define T8COC_SRC_DIV1024  3'h5
`define T8COC_SRC_FALL     3'h6
`define T8COC_SRC_RISE     3'h7
`endif

// ### hdl/t8coc_top.v
// 8-bit timer with two compare outputs, prescaler and interrupt flags
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "t8coc_regs.vh"

// Notes on behaviour
// - one clock; timer tick is an enable
// - nonzero channel a field drives the pin, except 01 in pwm without the upper bit and in reserved modes
// - channel a non-pwm: off, toggle, clear, set
// - channel a fast pwm actions at match/bottom
// - channel a phase pwm up/down match actions
// - nonzero channel b field drives the pin, except field 01 in pwm and any field in reserved modes
// - channel b non-pwm: off, toggle, clear, set
// - channel b fast pwm, field 01 reserved
// - channel b phase pwm, field 01 reserved
// - fast pwm compare at top acts at bottom
// - phase pwm compare at top acts at top
// - control a bits 3:2 read zero
// - mode code picks sequence and top source
// - buffer update and overflow point per mode
// - match a clears counter when top in modes 2 and 7, dual slope turns instead; flags
// - fast pwm counts to top then clears
// - tick source select: stop, divide, pin
module t8coc_top (
   // clock and reset
   input  wire       mclk,
   input  wire       reset,
   // register port
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_q,
   // external tick pin
   input  wire       tick_pin,
   // port logic shared with the compare pins
   input  wire       port_a_data,
   input  wire       port_a_dir,
   input  wire       port_b_data,
   input  wire       port_b_dir,
   output reg        pin_a_out_q,
   output reg        pin_a_oe_n_q,
   output reg        pin_b_out_q,
   output reg        pin_b_oe_n_q,
   // waveforms and interrupt
   output reg        chan_a_wave_out_q,
   output reg        chan_b_wave_out_q,
   output reg        irq_q
);
// ----------------------------------------------------------------
// mode classes, one-hot
// ----------------------------------------------------------------
localparam [3:0] CLS_NPWM = 4'h1; // normal and clear-on-match
localparam [3:0] CLS_FAST = 4'h2; // single slope
localparam [3:0] CLS_PC   = 4'h4; // dual slope
localparam [3:0] CLS_RSV  = 4'h8; // reserved codes
// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg  [7:0] ctl_a_q;       // timer_control_a
reg        upper_q;       // waveform_mode_upper_bit
reg  [2:0] src_q;         // tick_source_select
reg  [7:0] count_q;       // count_value
reg  [7:0] buf_a_q;       // compare a as written
reg  [7:0] buf_b_q;       // compare b as written
reg  [7:0] cmp_a_q;       // chan_a_compare_value in use
reg  [7:0] cmp_b_q;       // chan_b_compare_value in use
reg        down_q;        // dual slope counting down
reg        block_q;       // count write masks next match
reg  [2:0] flags_q;       // sticky event flags
reg  [2:0] mask_q;        // interrupt mask
reg  [9:0] presc_q;       // free prescaler
reg        tp1_q;         // pin sync stage 1
reg        tp2_q;         // pin sync stage 2
reg        tp3_q;         // pin sync stage 3
// ----------------------------------------------------------------
// helper functions
// ----------------------------------------------------------------
// mode code to class
function [3:0] cls_of;
   input [2:0] m;
   begin
      case (m)
         3'h0, 3'h2: cls_of = CLS_NPWM;
         3'h3, 3'h7: cls_of = CLS_FAST;
         3'h1, 3'h5: cls_of = CLS_PC;
         default:    cls_of = CLS_RSV;
      endcase
   end
endfunction
// whether a channel owns its pin
function conn_of;
   input [1:0] fld;
   input [3:0] cls;
   input       up_bit;
   input       chan_a;
   begin
      conn_of = (fld != 2'b00) && (cls != CLS_RSV);
      // toggle in pwm only on channel a with the upper bit
      if ((fld == 2'b01) && (cls != CLS_NPWM) && !(chan_a && up_bit))
         conn_of = 1'b0;
   end
endfunction
// next output level of one channel
function wave_next;
   input       cur;
   input [1:0] fld;
   input [3:0] cls;
   input       up_bit;
   input       chan_a;
   input       hit;       // compare match on a tick
   input       wrap;      // top to bottom on a tick
   input       top_hit;   // dual slope reaching top
   input       up;        // counting up at the tick
   input       cmp_top;   // compare value equals top
   begin
      wave_next = cur;
      case (cls)
         CLS_NPWM:
         begin
            if (hit)
            begin
               case (fld)
                  2'b01:   wave_next = ~cur;
                  2'b10:   wave_next = 1'b0;
                  2'b11:   wave_next = 1'b1;
                  default: wave_next = cur;
               endcase
            end
         end
         CLS_FAST, CLS_PC:
         begin
            if (fld == 2'b01)
            begin
               // b reserved; a toggles only with upper bit
               if (chan_a && up_bit && hit)
                  wave_next = ~cur;
            end
            else if (fld[1] && (cls == CLS_FAST))
            begin
               if (wrap)
                  wave_next = ~fld[0];
               else if (hit && !cmp_top)
                  wave_next = fld[0];
            end
            else if (fld[1])
            begin
               if (cmp_top)
               begin
                  if (top_hit)
                     wave_next = ~fld[0];
               end
               else if (hit)
                  wave_next = up ? fld[0] : ~fld[0];
            end
         end
         default: wave_next = cur;
      endcase
   end
endfunction
// ----------------------------------------------------------------
// decode of mode and top
// ----------------------------------------------------------------
wire [2:0] mode    = {upper_q, ctl_a_q[`T8COC_CTLA_WAVE]};
wire [3:0] cls     = cls_of(mode);
// compare a as top in modes 2, 5 and 7
wire       top_cmp = (mode == 3'h2) || (mode == 3'h5) || (mode == 3'h7);
wire [7:0] top     = top_cmp ? cmp_a_q : `T8COC_MAX;
wire [1:0] fld_a   = ctl_a_q[`T8COC_CTLA_MODE_A];
wire [1:0] fld_b   = ctl_a_q[`T8COC_CTLA_MODE_B];
// ----------------------------------------------------------------
// tick generation
// ----------------------------------------------------------------
wire pin_rise = tp2_q & ~tp3_q;
wire pin_fall = ~tp2_q & tp3_q;
reg  tick;  // one-cycle enable, never a clock
// choose the tick source; masks keep the compare at full prescaler width
always @*
begin
   case (src_q)
      `T8COC_SRC_CLK:     tick = 1'b1;
      `T8COC_SRC_DIV8:    tick = ((presc_q & `T8COC_DIV8_MASK) == `T8COC_DIV8_MASK);
      `T8COC_SRC_DIV64:   tick = ((presc_q & `T8COC_DIV64_MASK) == `T8COC_DIV64_MASK);
      `T8COC_SRC_DIV256:  tick = ((presc_q & `T8COC_DIV256_MASK) == `T8COC_DIV256_MASK);
      `T8COC_SRC_DIV1024: tick = (presc_q == `T8COC_DIV1024_MASK);
      `T8COC_SRC_FALL:    tick = pin_fall;
      `T8COC_SRC_RISE:    tick = pin_rise;
      default:            tick = 1'b0;
   endcase
end
// prescaler and pin synchroniser; prescaler runs free
always @(posedge mclk)
begin
   if (reset)
   begin
      presc_q <= 10'h000;
      tp1_q   <= 1'b0;
      tp2_q   <= 1'b0;
      tp3_q   <= 1'b0;
   end
   else
   begin
      presc_q <= presc_q + 10'h001;
      tp1_q   <= tick_pin;
      tp2_q   <= tp1_q;
      tp3_q   <= tp2_q;
   end
end
// ----------------------------------------------------------------
// counter events
// ----------------------------------------------------------------
wire at_top   = (count_q == top);
wire is_slope = (cls == CLS_FAST) || (cls == CLS_PC);
// wrap to bottom in single slope and clear-on-match
wire wrap     = tick && at_top && ((cls == CLS_FAST) || (mode == 3'h2));
wire top_hit  = tick && (cls == CLS_PC) && !down_q && at_top;
wire hit_a    = tick && !block_q && (count_q == cmp_a_q);
wire hit_b    = tick && !block_q && (count_q == cmp_b_q);
wire cmp_a_tp = is_slope && (cmp_a_q == top) && fld_a[1];
wire cmp_b_tp = is_slope && (cmp_b_q == top) && fld_b[1];
reg  ovf_ev;
// overflow point per class
always @*
begin
   case (cls)
      CLS_FAST: ovf_ev = wrap;
      CLS_PC:   ovf_ev = tick && down_q && (count_q == `T8COC_BOTTOM);
      default:  ovf_ev = tick && (count_q == `T8COC_MAX);
   endcase
end
// compare buffers load immediately, at top or at bottom
wire load_cmp = (cls == CLS_NPWM) || (cls == CLS_RSV) ||
                top_hit || ((cls == CLS_FAST) && wrap);
// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
wire wr_ctla = reg_wr && (reg_addr == `T8COC_OFS_CTL_A);
wire wr_ctlb = reg_wr && (reg_addr == `T8COC_OFS_CTL_B);
wire wr_cnt  = reg_wr && (reg_addr == `T8COC_OFS_COUNT);
wire wr_cmpa = reg_wr && (reg_addr == `T8COC_OFS_CMP_A);
wire wr_cmpb = reg_wr && (reg_addr == `T8COC_OFS_CMP_B);
wire wr_st   = reg_wr && (reg_addr == `T8COC_OFS_STATUS);
wire wr_mask = reg_wr && (reg_addr == `T8COC_OFS_MASK);
wire [2:0] st_clr = wr_st ? reg_wdata[2:0] : 3'h0;
wire [2:0] st_set = {hit_b, hit_a, ovf_ev};
// control, compare and flag registers
always @(posedge mclk)
begin
   if (reset)
   begin
      ctl_a_q <= `T8COC_RST_BYTE;
      upper_q <= 1'b0;
      src_q   <= `T8COC_RST_SRC;
      buf_a_q <= `T8COC_RST_BYTE;
      buf_b_q <= `T8COC_RST_BYTE;
      cmp_a_q <= `T8COC_RST_BYTE;
      cmp_b_q <= `T8COC_RST_BYTE;
      flags_q <= `T8COC_RST_FLAGS;
      mask_q  <= `T8COC_RST_FLAGS;
   end
   else
   begin
      if (wr_ctla)
         ctl_a_q <= reg_wdata;
      if (wr_ctlb)
      begin
         upper_q <= reg_wdata[`T8COC_CTLB_UPPER];
         src_q   <= reg_wdata[`T8COC_CTLB_SRC];
      end
      if (wr_cmpa)
         buf_a_q <= reg_wdata;
      if (wr_cmpb)
         buf_b_q <= reg_wdata;
      // double buffer: copy into use at the update point
      if (load_cmp)
      begin
         cmp_a_q <= wr_cmpa ? reg_wdata : buf_a_q;
         cmp_b_q <= wr_cmpb ? reg_wdata : buf_b_q;
      end
      if (wr_mask)
         mask_q <= reg_wdata[2:0];
      // set beats a clear in the same cycle
      flags_q <= (flags_q & ~st_clr) | st_set;
   end
end
// ----------------------------------------------------------------
// counter sequence
// ----------------------------------------------------------------
// updates wait for the tick enable, except a count write, which needs none
always @(posedge mclk)
begin
   if (reset)
   begin
      count_q <= `T8COC_BOTTOM;
      down_q  <= 1'b0;
      block_q <= 1'b0;
   end
   else if (wr_cnt)
   begin
      // a software write wins over the tick
      count_q <= reg_wdata;
      block_q <= 1'b1;
   end
   else if (tick)
   begin
      block_q <= 1'b0;
      case (cls)
         CLS_PC:
         begin
            if (!down_q && at_top)
            begin
               down_q  <= 1'b1;
               count_q <= count_q - 8'h01;
            end
            else if (down_q && (count_q == `T8COC_BOTTOM))
            begin
               down_q  <= 1'b0;
               count_q <= count_q + 8'h01;
            end
            else
               count_q <= down_q ? count_q - 8'h01 : count_q + 8'h01;
         end
         default:
         begin
            down_q <= 1'b0;
            if (wrap)
               count_q <= `T8COC_BOTTOM;
            else
               count_q <= count_q + 8'h01;
         end
      endcase
   end
end
// ----------------------------------------------------------------
// waveform outputs and pins
// ----------------------------------------------------------------
wire conn_a = conn_of(fld_a, cls, upper_q, 1'b1);
wire conn_b = conn_of(fld_b, cls, upper_q, 1'b0);
// waveform latches follow matches only while connected
always @(posedge mclk)
begin
   if (reset)
   begin
      chan_a_wave_out_q <= 1'b0;
      chan_b_wave_out_q <= 1'b0;
      pin_a_out_q       <= 1'b0;
      pin_b_out_q       <= 1'b0;
      pin_a_oe_n_q      <= 1'b1;
      pin_b_oe_n_q      <= 1'b1;
   end
   else
   begin
      chan_a_wave_out_q <= wave_next(chan_a_wave_out_q, fld_a, cls, upper_q,
                                     1'b1, hit_a, wrap, top_hit, !down_q,
                                     cmp_a_tp);
      chan_b_wave_out_q <= wave_next(chan_b_wave_out_q, fld_b, cls, upper_q,
                                     1'b0, hit_b, wrap, top_hit, !down_q,
                                     cmp_b_tp);
      // compare output overrides port data; direction keeps the driver
      pin_a_out_q  <= conn_a ? chan_a_wave_out_q : port_a_data;
      pin_b_out_q  <= conn_b ? chan_b_wave_out_q : port_b_data;
      pin_a_oe_n_q <= ~port_a_dir;
      pin_b_oe_n_q <= ~port_b_dir;
   end
end
// ----------------------------------------------------------------
// read port and interrupt
// ----------------------------------------------------------------
reg [7:0] rd_mux;
// read data select; unmapped reads zero
always @*
begin
   case (reg_addr)
      `T8COC_OFS_CTL_A:  rd_mux = {ctl_a_q[7:4], 2'b00, ctl_a_q[1:0]};
      `T8COC_OFS_CTL_B:  rd_mux = {4'h0, upper_q, src_q};
      `T8COC_OFS_COUNT:  rd_mux = count_q;
      `T8COC_OFS_CMP_A:  rd_mux = buf_a_q;
      `T8COC_OFS_CMP_B:  rd_mux = buf_b_q;
      `T8COC_OFS_STATUS: rd_mux = {5'h00, flags_q};
      `T8COC_OFS_MASK:   rd_mux = {5'h00, mask_q};
      default:           rd_mux = 8'h00;
   endcase
end
// read data valid one cycle after the strobe only
always @(posedge mclk)
begin
   if (reset)
   begin
      reg_rdata_q <= 8'h00;
      irq_q       <= 1'b0;
   end
   else
   begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      irq_q       <= |(flags_q & mask_q);
   end
end
endmodule // t8coc_top

// ### bench/t8coc_pin_load.sv
// load on a compare pin: resolves the wire level seen outside
`timescale 1ns/1ps
module t8coc_pin_load (
   // pin driver of the block
   input  wire  drv,
   input  wire  oe_n,
   // level on the wire
   output logic level
);
   // -----------------------------------------------
   // wire resolution
   // -----------------------------------------------
   // the board holds a pull-up, so a released pin reads high and never
   // keeps the last driven value
   assign level = oe_n ? 1'b1 : drv;
endmodule // t8coc_pin_load

// ### bench/t8coc_top_props.sv
// port checker for the timer compare-output block
`timescale 1ns/1ps
module t8coc_top_props (
   // clock and reset
   input wire       mclk,
   input wire       reset,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata_q,
   // port logic and pins
   input wire       port_a_data,
   input wire       port_a_dir,
   input wire       port_b_data,
   input wire       port_b_dir,
   input wire       pin_a_out_q,
   input wire       pin_a_oe_n_q,
   input wire       pin_b_out_q,
   input wire       pin_b_oe_n_q,
   // waveforms and interrupt
   input wire       chan_a_wave_out_q,
   input wire       chan_b_wave_out_q,
   input wire       irq_q
);
   // -----------------------------------------------
   // assertions
   // -----------------------------------------------
   a_rst_outputs:
   assert property (@(posedge mclk) reset |=> pin_a_oe_n_q && pin_b_oe_n_q
      && !chan_a_wave_out_q && !chan_b_wave_out_q && !irq_q)
      else $error("outputs not idle after reset");
   a_oe_follow_a:
   assert property (@(posedge mclk) disable iff (reset)
      !$past(reset) |-> pin_a_oe_n_q == !$past(port_a_dir))
      else $error("pin a enable not from direction");
   a_oe_follow_b:
   assert property (@(posedge mclk) disable iff (reset)
      !$past(reset) |-> pin_b_oe_n_q == !$past(port_b_dir))
      else $error("pin b enable not from direction");
   // a pin that differs from port data must be carrying the waveform
   a_pin_src_a:
   assert property (@(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && pin_a_out_q != $past(port_a_data)
      |-> pin_a_out_q == $past(chan_a_wave_out_q))
      else $error("pin a shows neither port nor wave");
   a_pin_src_b:
   assert property (@(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && pin_b_out_q != $past(port_b_data)
      |-> pin_b_out_q == $past(chan_b_wave_out_q))
      else $error("pin b shows neither port nor wave");
   a_ctl_rsvd:
   assert property (@(posedge mclk) disable iff (reset)
      $past(reg_rd) && $past(reg_addr) == 8'h30 |-> reg_rdata_q[3:2] == 2'b00)
      else $error("control a reserved bits not zero");
   a_rd_idle:
   assert property (@(posedge mclk) disable iff (reset)
      !$past(reg_rd) |-> reg_rdata_q == 8'h00)
      else $error("read data outside read slot");
   a_irq_mask_off:
   assert property (@(posedge mclk) disable iff (reset)
      reg_wr && reg_addr == 8'h39 && reg_wdata == 8'h00
      ##1 !(reg_wr && reg_addr == 8'h39) |=> !irq_q)
      else $error("interrupt high with mask cleared");
   // -----------------------------------------------
   // covers
   // -----------------------------------------------
   c_irq: cover property (@(posedge mclk) $rose(irq_q));
   c_wave_a: cover property (@(posedge mclk) $rose(chan_a_wave_out_q));
   c_pin_b: cover property (@(posedge mclk) !pin_b_oe_n_q && $fell(chan_b_wave_out_q));
endmodule // t8coc_top_props

// ### bench/t8coc_tb_top.sv
// self-checking bench for the 8-bit timer compare outputs
`timescale 1ns/1ps
`include "t8coc_regs.vh"
module t8coc_tb_top;
   // -----------------------------------------------
   // stimulus and observed signals
   // -----------------------------------------------
   logic       mclk        = 1'b0;
   logic       reset       = 1'b1;
   logic [7:0] reg_addr    = 8'h00;
   logic [7:0] reg_wdata   = 8'h00;
   logic       reg_wr      = 1'b0;
   logic       reg_rd      = 1'b0;
   logic       port_a_data = 1'b0;
   logic       port_a_dir  = 1'b0;
   logic       port_b_data = 1'b0;
   logic       port_b_dir  = 1'b0;
   wire  [7:0] reg_rdata_q;
   wire        pin_a_out_q, pin_a_oe_n_q, pin_b_out_q, pin_b_oe_n_q;
   wire        chan_a_wave_out_q, chan_b_wave_out_q, irq_q;
   wire        level_a, level_b;
   int         miscompares = 0;
   int         checked     = 0;
   logic       e;            // expected wave level in the field loop
   int         f;            // output-mode field under test
   logic [7:0] v0, v1;       // count samples around a tick window
   logic       tick_pin    = 1'b0;

   always #12.5 mclk = ~mclk;

   // external tick pin driven by the pin-edge scenario
   t8coc_top DUT (
      .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tick_pin(tick_pin),
      .port_a_data(port_a_data), .port_a_dir(port_a_dir),
      .port_b_data(port_b_data), .port_b_dir(port_b_dir),
      .pin_a_out_q(pin_a_out_q), .pin_a_oe_n_q(pin_a_oe_n_q),
      .pin_b_out_q(pin_b_out_q), .pin_b_oe_n_q(pin_b_oe_n_q),
      .chan_a_wave_out_q(chan_a_wave_out_q), .chan_b_wave_out_q(chan_b_wave_out_q),
      .irq_q(irq_q));
   t8coc_pin_load load_a (.drv(pin_a_out_q), .oe_n(pin_a_oe_n_q), .level(level_a));
   t8coc_pin_load load_b (.drv(pin_b_out_q), .oe_n(pin_b_oe_n_q), .level(level_b));

   // -----------------------------------------------
   // bus tasks and comparisons
   // -----------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic end_sim;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog: the tests need about 1,000 cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      end_sim;
   end

   // -----------------------------------------------
   // test sequence
   // -----------------------------------------------
   initial
   begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      cyc(1);
      chk1(pin_a_oe_n_q, 1'b1);
      rdchk(`T8COC_OFS_CTL_A, 8'h00);
      rdchk(`T8COC_OFS_CTL_B, 8'h00);
      rdchk(`T8COC_OFS_STATUS, 8'h00);
      wr(`T8COC_OFS_CTL_A, 8'hFF);
      rdchk(`T8COC_OFS_CTL_A, 8'hF3);
      rdchk(8'h31, 8'h00);
      @(posedge mclk);
      port_a_dir <= 1'b1;
      port_b_dir <= 1'b1;
      wr(`T8COC_OFS_CMP_A, 8'h05);
      wr(`T8COC_OFS_CMP_B, 8'h07);
      // non-pwm fields toggle, clear, set; counter stopped while set up
      e = 1'b0;
      for (f = 1; f < 4; f++)
      begin
         wr(`T8COC_OFS_CTL_B, 8'h00);
         wr(`T8COC_OFS_CTL_A, {f[1:0], f[1:0], 4'h0});
         wr(`T8COC_OFS_COUNT, 8'h00);
         wr(`T8COC_OFS_CTL_B, 8'h01);
         cyc(12);
         e = (f == 1) ? ~e : f[0];
         chk1(chan_a_wave_out_q, e);
         chk1(chan_b_wave_out_q, e);
         chk1(level_a, e);
         chk1(level_b, e);
      end
      rdchk(`T8COC_OFS_STATUS, 8'h06);
      // overflow at max raises the interrupt; write one clears it
      wr(`T8COC_OFS_STATUS, 8'h07);
      wr(`T8COC_OFS_MASK, 8'h01);
      wr(`T8COC_OFS_COUNT, 8'hFD);
      cyc(5);
      chk1(irq_q, 1'b1);
      wr(`T8COC_OFS_STATUS, 8'h07);
      cyc(2);
      chk1(irq_q, 1'b0);
      wr(`T8COC_OFS_MASK, 8'h00);
      // fast pwm, non-inverting: set at bottom, clear on match
      wr(`T8COC_OFS_CTL_B, 8'h00);
      wr(`T8COC_OFS_CMP_A, 8'h80);
      wr(`T8COC_OFS_CMP_B, 8'h40);
      wr(`T8COC_OFS_CTL_A, 8'hA3);
      wr(`T8COC_OFS_COUNT, 8'hF0);
      wr(`T8COC_OFS_CTL_B, 8'h01);
      cyc(48);
      chk1(chan_a_wave_out_q, 1'b1);
      chk1(chan_b_wave_out_q, 1'b1);
      cyc(64);
      chk1(chan_a_wave_out_q, 1'b1);
      chk1(chan_b_wave_out_q, 1'b0);
      cyc(64);
      chk1(chan_a_wave_out_q, 1'b0);
      // reserved channel b field leaves the pin to port data
      wr(`T8COC_OFS_CTL_A, 8'h93);
      port_b_data <= 1'b1;
      cyc(3);
      chk1(pin_b_out_q, 1'b1);
      @(posedge mclk);
      port_b_data <= 1'b0;
      cyc(3);
      chk1(pin_b_out_q, 1'b0);
      // phase correct, inverting: set on up match, clear on down match
      wr(`T8COC_OFS_CTL_B, 8'h00);
      wr(`T8COC_OFS_CTL_A, 8'hF1);
      wr(`T8COC_OFS_COUNT, 8'h00);
      wr(`T8COC_OFS_CTL_B, 8'h01);
      cyc(160);
      chk1(chan_a_wave_out_q, 1'b1);
      chk1(chan_b_wave_out_q, 1'b1);
      cyc(240);
      chk1(chan_a_wave_out_q, 1'b0);
      chk1(chan_b_wave_out_q, 1'b1);
      cyc(80);
      chk1(chan_b_wave_out_q, 1'b0);
      // divide by 8: any 64-cycle window holds exactly 8 ticks
      wr(`T8COC_OFS_CTL_A, 8'h00);
      wr(`T8COC_OFS_CTL_B, 8'h02);
      rd(`T8COC_OFS_COUNT, v0);
      cyc(62);
      rd(`T8COC_OFS_COUNT, v1);
      chk8(v1 - v0, 8'h08);
      // pin source: only the chosen edge counts
      for (f = 6; f < 8; f++)
      begin
         wr(`T8COC_OFS_CTL_B, f[7:0]);
         rd(`T8COC_OFS_COUNT, v0);
         @(posedge mclk);
         tick_pin <= 1'b1;
         cyc(5);
         rd(`T8COC_OFS_COUNT, v1);
         chk8(v1 - v0, {7'h00, f[0]});
         @(posedge mclk);
         tick_pin <= 1'b0;
         cyc(5);
         rd(`T8COC_OFS_COUNT, v0);
         chk8(v0 - v1, {7'h00, ~f[0]});
      end
      // clear-on-match: counter runs 0..5 and sets flag a only
      wr(`T8COC_OFS_CMP_A, 8'h05);
      wr(`T8COC_OFS_STATUS, 8'h07);
      wr(`T8COC_OFS_CTL_A, 8'h02);
      wr(`T8COC_OFS_COUNT, 8'h00);
      wr(`T8COC_OFS_CTL_B, 8'h01);
      cyc(20);
      rdchk(`T8COC_OFS_COUNT, 8'h03);
      rdchk(`T8COC_OFS_STATUS, 8'h02);
      end_sim;
   end
endmodule // t8coc_tb_top

bind t8coc_top t8coc_top_props u_props (
   .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .port_a_data(port_a_data), .port_a_dir(port_a_dir),
   .port_b_data(port_b_data), .port_b_dir(port_b_dir),
   .pin_a_out_q(pin_a_out_q), .pin_a_oe_n_q(pin_a_oe_n_q),
   .pin_b_out_q(pin_b_out_q), .pin_b_oe_n_q(pin_b_oe_n_q),
   .chan_a_wave_out_q(chan_a_wave_out_q), .chan_b_wave_out_q(chan_b_wave_out_q),
   .irq_q(irq_q));
